/* File: core/channel_mux.sv */
// Multiplexer end: 16 full-duplex teletype channels behind one select code.
// Assumes units on the user side share clk, so no synchronisers are used.
//
// Notes on behaviour
// - Pulse interrupt level 30 every 90 ms.
// - Every unit has the tick; one enabled.
// - Function select picks this unit and channel.
// - Input word carries status in top bits.
// - Bit 11 flags waiting character, low eight.
// - Bit 10 flags channel ready for output.
// - Host sends output character in low bits.
// - Host polls every channel after each tick.
// - Upper six bits select unit group.
// - Two master bits, group bit, channel bits.
// - Two slave groups of eight per master.
// - Operator sets the sixteen-channel address.
// - Monitor mode reports lost flags as data.
`timescale 1ns/1ps
`default_nettype none
module channel_mux
   import mux_pkg::*;
#(
   parameter int TICK_CYCLES = IRQ_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host channel
   mux_link_if.device link,
   // Operator settings
   input wire logic tick_source_en,
   input wire logic [UNIT_W-1:0] unit_addr,
   input wire logic [MASTER_W-1:0] master_addr,
   input wire logic monitor_mode,
   // Low speed input units
   input wire logic [CHANNELS-1:0] rx_valid,
   input wire logic [CHANNELS-1:0][CHAR_W-1:0] rx_char,
   input wire logic [CHANNELS-1:0] rx_idle,
   input wire logic [CHANNELS-1:0][CHAR_W-1:0] lost_flags,
   // Low speed output units
   input wire logic [CHANNELS-1:0] tx_ready,
   output logic [CHANNELS-1:0] tx_valid,
   output logic [CHAR_W-1:0] tx_char,
   // Selection state
   output logic selected,
   output logic [CHAN_W-1:0] sel_chan
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   logic [TICK_W-1:0] tick_reg;
   logic resume_reg;
   logic in_ready_reg;
   logic [WORD_W-1:0] in_word_reg;
   logic selected_reg;
   logic [CHAN_W-1:0] chan_reg;
   logic [CHANNELS-1:0] tx_valid_reg;
   logic [CHAR_W-1:0] tx_char_reg;
   logic irq_reg;
   logic [CHANNELS-1:0] full_reg;
   logic [CHANNELS-1:0] lost_reg;
   logic [CHAR_W-1:0] char_reg [CHANNELS];
   logic addressed;
   logic take_func;
   logic take_in;
   logic take_out;
   logic [WORD_W-1:0] word_next;

   // Link and user outputs come straight from flops
   assign link.irq = irq_reg;
   assign link.out_resume = resume_reg;
   assign link.in_ready = in_ready_reg;
   assign link.in_word = in_word_reg;
   assign tx_valid = tx_valid_reg;
   assign tx_char = tx_char_reg;
   assign selected = selected_reg;
   assign sel_chan = chan_reg;

   // Unit group and master match; group bit and channel bits are kept
   // whole, so both slave groups of eight answer under one master
   assign addressed = (link.func_code[UNIT_HI:UNIT_LO] == unit_addr) &&
      (link.func_code[MASTER_HI:MASTER_LO] == master_addr);

   // A request is taken once; the resume pulse blocks a second take while
   // the host is still dropping its ready line
   assign take_func = link.func_ready && !resume_reg;
   assign take_in = link.in_request && !in_ready_reg && selected_reg;
   assign take_out = link.info_ready && !link.func_ready && !resume_reg &&
      selected_reg;

   // Input word assembly for the selected channel
   always_comb begin
      word_next = WORD_RESET;
      word_next[BIT_OUT_READY] = tx_ready[chan_reg];
      word_next[BIT_BREAK_IDLE] = rx_idle[chan_reg];
      if (monitor_mode) begin
         // Monitor slave: lost flags of eight receive circuits as data
         word_next[CHAR_W-1:0] = lost_flags[chan_reg];
         word_next[BIT_CHAR_READY] = |lost_flags[chan_reg];
      end else begin
         word_next[BIT_CHAR_READY] = full_reg[chan_reg];
         word_next[BIT_CHAR_LOST] = lost_reg[chan_reg];
         word_next[CHAR_W-1:0] = char_reg[chan_reg];
      end
   end

   // Periodic tick; only the unit with the source enabled drives it
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_reg <= '0;
         irq_reg <= 1'b0;
      end else if (tick_reg == TICK_LAST) begin
         tick_reg <= '0;
         irq_reg <= tick_source_en;
      end else begin
         tick_reg <= tick_reg + 1'b1;
         irq_reg <= 1'b0;
      end
   end

   // Function select: latch selection and channel, answer with resume
   always_ff @(posedge clk) begin
      if (rst) begin
         selected_reg <= 1'b0;
         chan_reg <= CHAN_RESET;
      end else if (take_func) begin
         selected_reg <= addressed;
         chan_reg <= {link.func_code[GROUP_BIT],
            link.func_code[CHAN_HI:0]};
      end
   end

   // Resume answers a select to us or an output word while selected
   always_ff @(posedge clk) begin
      if (rst) begin
         resume_reg <= 1'b0;
      end else if (resume_reg) begin
         resume_reg <= 1'b0;
      end else if (link.func_ready) begin
         resume_reg <= addressed;
      end else begin
         resume_reg <= take_out;
      end
   end

   // Input request: one word per request, status on top
   always_ff @(posedge clk) begin
      if (rst) begin
         in_ready_reg <= 1'b0;
         in_word_reg <= WORD_RESET;
      end else if (take_in) begin
         in_ready_reg <= 1'b1;
         in_word_reg <= word_next;
      end else begin
         in_ready_reg <= 1'b0;
      end
   end

   // Output word: low eight bits go to the unit if it can take them;
   // a word to a busy unit is resumed but dropped, so the host never hangs
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_valid_reg <= '0;
         tx_char_reg <= '0;
      end else begin
         tx_valid_reg <= '0;
         if (take_out && tx_ready[chan_reg]) begin
            tx_valid_reg[chan_reg] <= 1'b1;
            tx_char_reg <= link.out_word[CHAR_W-1:0];
         end
      end
   end

   // Per-channel receive holding; a new character wins over a read clear
   for (genvar i = 0; i < CHANNELS; i++) begin : g_rx
      logic read_hit;
      assign read_hit = take_in && !monitor_mode &&
         (chan_reg == CHAN_W'(i));
      always_ff @(posedge clk) begin
         if (rst) begin
            full_reg[i] <= 1'b0;
            lost_reg[i] <= 1'b0;
            char_reg[i] <= '0;
         end else begin
            if (rx_valid[i]) begin
               full_reg[i] <= 1'b1;
               char_reg[i] <= rx_char[i];
            end else if (read_hit) begin
               full_reg[i] <= 1'b0;
            end
            // Overrun: character arrived over one never read
            if (rx_valid[i] && full_reg[i] && !read_hit) begin
               lost_reg[i] <= 1'b1;
            end else if (read_hit) begin
               lost_reg[i] <= 1'b0;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: inc/mux_pkg.sv */
// Shared constants and types for the teletype channel multiplexer link.
// Assumes both ends run on one 40 MHz clock with a synchronous reset.
package mux_pkg;
   // Channel and word geometry
   localparam int CHANNELS = 16;
   localparam int WORD_W = 12;
   localparam int CHAR_W = 8;
   localparam int CHAN_W = 4;
   // Input word status positions
   localparam int BIT_CHAR_READY = 11;
   localparam int BIT_OUT_READY = 10;
   localparam int BIT_CHAR_LOST = 9;
   localparam int BIT_BREAK_IDLE = 8;
   // Select code fields
   localparam int UNIT_HI = 11;
   localparam int UNIT_LO = 6;
   localparam int MASTER_HI = 5;
   localparam int MASTER_LO = 4;
   localparam int GROUP_BIT = 3;
   localparam int CHAN_HI = 2;
   localparam int UNIT_W = 6;
   localparam int MASTER_W = 2;
   // Host interrupt level used by the periodic tick
   localparam int IRQ_LEVEL = 30;
   // Periodic interrupt timing
   localparam longint CLK_HZ = 40000000;
   localparam longint IRQ_PERIOD_MS = 90;
   localparam int IRQ_CYCLES = int'((IRQ_PERIOD_MS * CLK_HZ) / 1000);
   // Values after reset
   localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
   // Host scan sequencer states
   typedef enum logic [2:0] {
      H_IDLE, H_SEL, H_SEL_WAIT, H_RD, H_RD_WAIT, H_WR_WAIT, H_NEXT
   } host_state_t;
endpackage

/* File: inc/mux_link_if.sv */
// Parallel channel between host and multiplexer: select, input, output.
// Assumes both parties share clk; every signal is a registered level.
`timescale 1ns/1ps
`default_nettype none
interface mux_link_if;
   import mux_pkg::*;
   logic irq;
   logic func_ready;
   logic [WORD_W-1:0] func_code;
   logic info_ready;
   logic [WORD_W-1:0] out_word;
   logic out_resume;
   logic in_request;
   logic in_ready;
   logic [WORD_W-1:0] in_word;
   modport device (
      output irq, out_resume, in_ready, in_word,
      input func_ready, func_code, info_ready, out_word, in_request
   );
   modport host (
      input irq, out_resume, in_ready, in_word,
      output func_ready, func_code, info_ready, out_word, in_request
   );
endinterface
`default_nettype wire

/* File: core/channel_host.sv */
// Host end: on each tick, select and read every channel, send waiting output.
// Assumes the multiplexer answers each select and request on the shared clk.
`timescale 1ns/1ps
`default_nettype none
module channel_host
   import mux_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host channel
   mux_link_if.host link,
   // Target multiplexer address
   input wire logic [UNIT_W-1:0] unit_addr,
   input wire logic [MASTER_W-1:0] master_addr,
   // Characters waiting to be sent
   input wire logic [CHANNELS-1:0] tx_pending,
   input wire logic [CHANNELS-1:0][CHAR_W-1:0] tx_data,
   output logic [CHANNELS-1:0] tx_taken,
   // Poll results
   output logic poll_valid,
   output logic [CHAN_W-1:0] poll_chan,
   output logic [WORD_W-1:0] poll_word,
   output logic scan_busy
);

   host_state_t state_reg;
   logic [CHAN_W-1:0] chan_reg;
   logic tick_seen_reg;
   logic func_ready_reg;
   logic [WORD_W-1:0] func_code_reg;
   logic in_request_reg;
   logic info_ready_reg;
   logic [WORD_W-1:0] out_word_reg;
   logic poll_valid_reg;
   logic [WORD_W-1:0] poll_word_reg;
   logic [CHANNELS-1:0] tx_taken_reg;
   logic scan_busy_reg;

   assign link.func_ready = func_ready_reg;
   assign link.func_code = func_code_reg;
   assign link.in_request = in_request_reg;
   assign link.info_ready = info_ready_reg;
   assign link.out_word = out_word_reg;
   assign tx_taken = tx_taken_reg;
   assign poll_valid = poll_valid_reg;
   assign poll_chan = chan_reg;
   assign poll_word = poll_word_reg;
   // Busy is kept in its own flop so the output is glitch free
   assign scan_busy = scan_busy_reg;

   // A tick during a scan is kept so a fresh scan follows; set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_seen_reg <= 1'b0;
      end else if (link.irq) begin
         tick_seen_reg <= 1'b1;
      end else if (state_reg == H_IDLE) begin
         tick_seen_reg <= 1'b0;
      end
   end

   // Scan sequencer, one channel at a time, all sixteen per tick
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= H_IDLE;
         chan_reg <= CHAN_RESET;
         func_ready_reg <= 1'b0;
         func_code_reg <= WORD_RESET;
         in_request_reg <= 1'b0;
         info_ready_reg <= 1'b0;
         out_word_reg <= WORD_RESET;
         poll_valid_reg <= 1'b0;
         poll_word_reg <= WORD_RESET;
         tx_taken_reg <= '0;
         scan_busy_reg <= 1'b0;
      end else begin
         poll_valid_reg <= 1'b0;
         tx_taken_reg <= '0;
         case (state_reg)
            H_IDLE: begin
               if (tick_seen_reg) begin
                  chan_reg <= CHAN_RESET;
                  scan_busy_reg <= 1'b1;
                  state_reg <= H_SEL;
               end
            end
            H_SEL: begin
               func_ready_reg <= 1'b1;
               func_code_reg <= {unit_addr, master_addr, chan_reg};
               state_reg <= H_SEL_WAIT;
            end
            H_SEL_WAIT: begin
               if (link.out_resume) begin
                  func_ready_reg <= 1'b0;
                  state_reg <= H_RD;
               end
            end
            H_RD: begin
               in_request_reg <= 1'b1;
               state_reg <= H_RD_WAIT;
            end
            H_RD_WAIT: begin
               if (link.in_ready) begin
                  in_request_reg <= 1'b0;
                  poll_valid_reg <= 1'b1;
                  poll_word_reg <= link.in_word;
                  if (link.in_word[BIT_OUT_READY] &&
                     tx_pending[chan_reg]) begin
                     info_ready_reg <= 1'b1;
                     out_word_reg <= {4'h0, tx_data[chan_reg]};
                     state_reg <= H_WR_WAIT;
                  end else begin
                     state_reg <= H_NEXT;
                  end
               end
            end
            H_WR_WAIT: begin
               if (link.out_resume) begin
                  info_ready_reg <= 1'b0;
                  tx_taken_reg[chan_reg] <= 1'b1;
                  state_reg <= H_NEXT;
               end
            end
            H_NEXT: begin
               if (chan_reg == CHAN_W'(CHANNELS - 1)) begin
                  scan_busy_reg <= 1'b0;
                  state_reg <= H_IDLE;
               end else begin
                  chan_reg <= chan_reg + 1'b1;
                  state_reg <= H_SEL;
               end
            end
            default: begin
               scan_busy_reg <= 1'b0;
               state_reg <= H_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: test/mux_link_sva.sv */
// Concurrent checks on the link between host end and multiplexer end.
// Assumes one clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ps
`default_nettype none
module mux_link_sva
   import mux_pkg::*;
#(
   parameter int TICK_CYCLES = IRQ_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link signals
   input wire logic irq,
   input wire logic func_ready,
   input wire logic [WORD_W-1:0] func_code,
   input wire logic info_ready,
   input wire logic [WORD_W-1:0] out_word,
   input wire logic out_resume,
   input wire logic in_request,
   input wire logic in_ready,
   input wire logic [WORD_W-1:0] in_word
);
   logic [31:0] gap_reg;
   logic seen_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles since the last tick; the first tick is not judged
   always_ff @(posedge clk) begin
      if (rst || irq) begin
         gap_reg <= 32'h0;
      end else begin
         gap_reg <= gap_reg + 32'h1;
      end
   end
   // Spacing is only meaningful once one tick has been seen
   always_ff @(posedge clk) begin
      if (rst) begin
         seen_reg <= 1'b0;
      end else if (irq) begin
         seen_reg <= 1'b1;
      end
   end
   sequence sel_ack_s;
      out_resume ##1 !func_ready;
   endsequence
   sequence rd_ack_s;
      in_ready ##1 !in_request;
   endsequence
   sequence wr_ack_s;
      out_resume ##1 !info_ready;
   endsequence
   tick_period_a: assert property (
      irq && seen_reg |-> gap_reg == TICK_CYCLES - 1)
      else $error("tick spacing wrong");
   tick_pulse_a: assert property (irq |=> !irq)
      else $error("tick longer than one cycle");
   sel_answer_a: assert property ($rose(func_ready) |=> sel_ack_s)
      else $error("select not answered");
   code_hold_a: assert property (
      func_ready && $past(func_ready) |-> $stable(func_code))
      else $error("select code moved");
   read_answer_a: assert property ($rose(in_request) |=> rd_ack_s)
      else $error("input request not answered");
   word_hold_a: assert property (!in_ready |-> $stable(in_word))
      else $error("input word changed without read");
   lost_char_a: assert property (
      in_ready && in_word[BIT_CHAR_LOST] |-> in_word[BIT_CHAR_READY])
      else $error("lost flag without waiting char");
   out_bits_a: assert property (
      info_ready |-> out_word[WORD_W-1:CHAR_W] == 4'h0)
      else $error("output word upper bits set");
   write_answer_a: assert property (
      $rose(info_ready) |=> wr_ack_s)
      else $error("output word not answered");
   resume_cause_a: assert property (
      out_resume |-> $past(func_ready) || $past(info_ready))
      else $error("resume without request");
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench: host end and multiplexer end joined by the link.
// Assumes a short tick period so several scans fit in one run.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mux_pkg::*;
   localparam int TICK = 400;
   localparam int LIMIT = 12000;
   // Data bits are judged only where the character is known
   typedef struct {
      logic [3:0] chan;
      logic [11:0] word;
      logic keep;
   } poll_exp_t;
   typedef struct {logic [15:0] hot; logic [7:0] ch;} tx_exp_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tick_source_en = 1'b1, monitor_mode = 1'b0;
   logic [UNIT_W-1:0] unit_addr = 6'h00;
   logic [MASTER_W-1:0] master_addr = 2'h0;
   logic [CHANNELS-1:0] rx_valid = '0, rx_idle = '0;
   logic [CHANNELS-1:0] tx_ready = '0, tx_pending = '0;
   logic [CHANNELS-1:0] last_hot = '0;
   logic [CHANNELS-1:0][CHAR_W-1:0] rx_char = '0, lost_flags = '0;
   logic [CHANNELS-1:0][CHAR_W-1:0] tx_data = '0;
   logic [CHANNELS-1:0] tx_valid, tx_taken;
   logic [CHAR_W-1:0] tx_char;
   logic selected, poll_valid, scan_busy;
   logic [CHAN_W-1:0] sel_chan, poll_chan;
   logic [WORD_W-1:0] poll_word;
   int bad_count = 0, n_compared = 0, cycles = 0, seed = 64436, seen;
   poll_exp_t pq[$], pe;
   tx_exp_t tq[$], te;
   mux_link_if link ();
   channel_mux #(.TICK_CYCLES(TICK)) i_channel_mux (.clk(clk), .rst(rst),
      .link(link), .tick_source_en(tick_source_en), .unit_addr(unit_addr),
      .master_addr(master_addr), .monitor_mode(monitor_mode),
      .rx_valid(rx_valid), .rx_char(rx_char), .rx_idle(rx_idle),
      .lost_flags(lost_flags), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_char(tx_char), .selected(selected), .sel_chan(sel_chan));
   channel_host i_channel_host (.clk(clk), .rst(rst), .link(link),
      .unit_addr(unit_addr), .master_addr(master_addr),
      .tx_pending(tx_pending), .tx_data(tx_data), .tx_taken(tx_taken),
      .poll_valid(poll_valid), .poll_chan(poll_chan), .poll_word(poll_word),
      .scan_busy(scan_busy));
   mux_link_sva #(.TICK_CYCLES(TICK)) i_mux_link_sva (.clk(clk), .rst(rst),
      .irq(link.irq), .func_ready(link.func_ready),
      .func_code(link.func_code), .info_ready(link.info_ready),
      .out_word(link.out_word), .out_resume(link.out_resume),
      .in_request(link.in_request), .in_ready(link.in_ready),
      .in_word(link.in_word));
   // Clock at 40 MHz
   always #12.5 clk = ~clk;
   task automatic check(input string what, input logic [31:0] got,
                        input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Load one scan's worth of traffic and note what the host must see
   task automatic round(input logic mon);
      int n [CHANNELS];
      poll_exp_t e;
      tx_exp_t t;
      monitor_mode = mon;
      tx_ready = 16'($random(seed));
      rx_idle = 16'($random(seed));
      tx_pending = 16'($random(seed));
      for (int c = 0; c < CHANNELS; c++) begin
         tx_data[c] = 8'($random(seed));
         lost_flags[c] = 8'($random(seed));
         n[c] = mon ? 0 : int'($unsigned($random(seed)) % 3);
      end
      // Two arrivals on one channel overrun its holding place
      for (int k = 0; k < 2; k++) begin
         for (int c = 0; c < CHANNELS; c++) begin
            rx_valid[c] = (n[c] > k);
            if (n[c] > k) rx_char[c] = 8'($random(seed));
         end
         @(posedge clk);
         #2 rx_valid = '0;
      end
      for (int c = 0; c < CHANNELS; c++) begin
         e.chan = 4'(c);
         if (mon) begin
            e.word = {|lost_flags[c], tx_ready[c], 1'b0, rx_idle[c],
               lost_flags[c]};
            e.keep = 1'b1;
         end else begin
            e.word = {n[c] > 0, tx_ready[c], n[c] > 1, rx_idle[c], rx_char[c]};
            e.keep = (n[c] != 0);
         end
         pq.push_back(e);
         t.hot = 16'h0001 << c;
         t.ch = tx_data[c];
         if (tx_pending[c] && tx_ready[c]) tq.push_back(t);
      end
      while (scan_busy !== 1'b1) @(posedge clk);
      while (scan_busy !== 1'b0) @(posedge clk);
      #2;
   endtask
   // Main sequence
   initial begin
      unit_addr = 6'($random(seed));
      master_addr = 2'($random(seed));
      repeat (10) @(posedge clk);
      #2 rst = 1'b0;
      for (int r = 0; r < 6; r++) begin
         round(r >= 4);
         $display("test scan round %0d done", r);
      end
      check("poll left", pq.size(), 0);
      check("tx left", tq.size(), 0);
      tick_source_en = 1'b0;
      seen = 0;
      repeat (2 * TICK) begin
         @(negedge clk);
         if (link.irq === 1'b1) seen++;
      end
      check("idle ticks", seen, 0);
      $display("test tick disable done");
      report_and_stop();
   end
   // Accepted characters leave the pending set; only written on a take
   // so it never races the round that reloads the set
   always @(posedge clk) begin
      #2 if (tx_taken !== '0) tx_pending = tx_pending & ~tx_taken;
   end
   // Poll results against the oldest note, sampled mid-cycle
   always @(negedge clk) begin
      if (poll_valid === 1'b1) begin
         if (pq.size() == 0) begin
            check("poll extra", 1, 0);
         end else begin
            pe = pq.pop_front();
            check("poll chan", poll_chan, pe.chan);
            check("sel chan", sel_chan, pe.chan);
            check("selected", selected, 1'b1);
            check("status", poll_word[11:8], pe.word[11:8]);
            if (pe.keep) check("data", poll_word[7:0], pe.word[7:0]);
         end
      end
   end
   // Output characters against the oldest note, sampled mid-cycle
   always @(negedge clk) begin
      if (tx_taken !== '0) begin
         check("tx taken", tx_taken, last_hot);
      end
      if (tx_valid !== '0) begin
         if (tq.size() == 0) begin
            check("tx extra", 1, 0);
         end else begin
            te = tq.pop_front();
            last_hot = te.hot;
            check("tx lane", tx_valid, te.hot);
            check("tx char", tx_char, te.ch);
         end
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         report_and_stop();
      end
   end
endmodule
`default_nettype wire
